/* logic/ovm_pkg.sv */
// Purpose: Shared constants, types and helpers of the output voltage limit monitor
// Assumes: Limit codes are unsigned, one count is 2^-13 V
// Notes:   Command codes double as register addresses on the command port
package ovm_pkg;

    localparam logic [7:0]  CMD_OV_WARN       = 8'h42;
    localparam logic [7:0]  CMD_UV_WARN       = 8'h43;
    localparam logic [7:0]  CMD_UV_TRIP       = 8'h44;
    localparam logic [7:0]  CMD_UV_ACTION     = 8'h45;
    localparam logic [7:0]  CMD_CLEAR_FAULTS  = 8'h03;
    localparam logic [7:0]  CMD_SUMMARY       = 8'h79;
    localparam logic [7:0]  CMD_VOUT_FLAGS    = 8'h7a;

    // 5.5 V expressed in 2^-13 V counts
    localparam logic [15:0] LIMIT_MAX         = 16'hb000;
    localparam logic [15:0] UV_TRIP_RESET     = 16'h0ccd;
    localparam logic [15:0] LIMIT_RESET       = 16'h0000;
    localparam logic [7:0]  UV_ACTION_RESET   = 8'hb8;
    localparam logic [7:0]  FLAGS_RESET       = 8'h00;

    // Strap scale factors in 1/1024 units: 1.08 and 0.88
    localparam logic [10:0] OV_WARN_SCALE     = 11'h452;
    localparam logic [10:0] UV_WARN_SCALE     = 11'h385;
    localparam int          SCALE_SHIFT       = 10;

    localparam int          ACT_MSB           = 7;
    localparam int          ACT_LSB           = 6;
    localparam int          RETRY_MSB         = 5;
    localparam int          RETRY_LSB         = 3;
    localparam int          DELAY_MSB         = 2;
    localparam int          DELAY_LSB         = 0;
    localparam logic [1:0]  ACT_DISABLE_RETRY = 2'h2;
    localparam logic [2:0]  RETRY_NONE        = 3'h0;

    localparam int          FLAG_OV_TRIP      = 7;
    localparam int          FLAG_OV_WARN      = 6;
    localparam int          FLAG_UV_WARN      = 5;
    localparam int          FLAG_UV_TRIP      = 4;
    localparam int          SUMMARY_VOUT_BIT  = 15;

    localparam logic [15:0] RETRY_UNIT_MS     = 16'd35;
    localparam int          CLK_PERIOD_NS     = 10;
    localparam int          MS_NS             = 1000000;
    localparam int          MS_CYCLES         = MS_NS / CLK_PERIOD_NS;
    localparam logic [1:0]  STRAP_SETTLE      = 2'h3;

    typedef enum logic [1:0] {ST_RUN, ST_RETRY_WAIT, ST_TON_WAIT, ST_LATCHED} ovm_state_type;

    function automatic logic [15:0] ovm_scale(input logic [15:0] code, input logic [10:0] factor);
        logic [26:0] prod;
        prod = code * factor;
        ovm_scale = (prod[26:SCALE_SHIFT] > {1'b0, 16'hffff}) ? 16'hffff : prod[25:SCALE_SHIFT];
    endfunction

    function automatic logic ovm_limit_ok(input logic [15:0] code);
        ovm_limit_ok = (code <= LIMIT_MAX);
    endfunction

endpackage

/* logic/ovm_mon_if.sv */
// Purpose: Carries timer and comparator signals between monitor modules
// Assumes: All signals on mclk
// Notes:   ctrl side is the register bank
`timescale 1ns/1ns
interface ovm_mon_if;
    logic        tmr_start;
    logic [15:0] tmr_ms;
    logic        tmr_done;
    logic [15:0] vout;
    logic [15:0] ov_warn;
    logic [15:0] uv_warn;
    logic [15:0] uv_trip;
    logic        above_ov_warn;
    logic        below_uv_warn;
    logic        below_uv_trip;

    modport ctrl    (output tmr_start, tmr_ms, vout, ov_warn, uv_warn, uv_trip,
                     input  tmr_done, above_ov_warn, below_uv_warn, below_uv_trip);
    modport timer   (input  tmr_start, tmr_ms, output tmr_done);
    modport compare (input  vout, ov_warn, uv_warn, uv_trip,
                     output above_ov_warn, below_uv_warn, below_uv_trip);
endinterface

/* logic/ovm_ms_timer.sv */
// Purpose: Millisecond down-counter, one-cycle done pulse on expiry
// Assumes: Start restarts the count at once
// Notes:   A count of zero expires after one millisecond
`timescale 1ns/1ns
module ovm_ms_timer
    import ovm_pkg::*;
#(
    parameter int MS_CYC = MS_CYCLES
)
(
    input wire logic mclk,
    input wire logic nrst,
    ovm_mon_if.timer mon
);
    localparam int PW = $clog2(MS_CYC + 1);
    localparam logic [PW-1:0] PRE_LOAD = PW'(MS_CYC - 1);

    initial
    begin
        if (MS_CYC < 2)
            $error("ovm_ms_timer: MS_CYC must be at least 2");
    end

    typedef struct packed {
        logic          busy;
        logic [PW-1:0] prescale;
        logic [15:0]   ms_left;
        logic          done;
    } ovm_tmr_type;

    ovm_tmr_type s;
    ovm_tmr_type next_s;

    always_comb
    begin
        next_s = s;
        next_s.done = 1'b0;
        if (mon.tmr_start)
        begin
            next_s.busy = 1'b1;
            next_s.prescale = PRE_LOAD;
            next_s.ms_left = mon.tmr_ms;
        end
        else if (s.busy)
        begin
            if (s.prescale == '0)
            begin
                next_s.prescale = PRE_LOAD;
                if (s.ms_left <= 16'h0001)
                begin
                    next_s.busy = 1'b0;
                    next_s.done = 1'b1;
                end
                else
                    next_s.ms_left = s.ms_left - 16'h0001;
            end
            else
                next_s.prescale = s.prescale - PW'(1);
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            s <= '0;
        else
            s <= next_s;
    end

    assign mon.tmr_done = s.done;
endmodule

/* logic/ovm_compare.sv */
// Purpose: Registered comparison of output voltage against the limits
// Assumes: Voltage and limits share the 2^-13 V scale
// Notes:   Unfiltered, short excursions may slip between samples
`timescale 1ns/1ns
module ovm_compare
    import ovm_pkg::*;
(
    input wire logic   mclk,
    input wire logic   nrst,
    ovm_mon_if.compare mon
);
    typedef struct packed {
        logic above_ov_warn;
        logic below_uv_warn;
        logic below_uv_trip;
    } ovm_cmp_type;

    ovm_cmp_type s;
    ovm_cmp_type next_s;

    always_comb
    begin
        next_s = s;
        next_s.above_ov_warn = (mon.vout > mon.ov_warn);
        next_s.below_uv_warn = (mon.vout < mon.uv_warn);
        next_s.below_uv_trip = (mon.vout < mon.uv_trip);
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            s <= '0;
        else
            s <= next_s;
    end

    assign mon.above_ov_warn = s.above_ov_warn;
    assign mon.below_uv_warn = s.below_uv_warn;
    assign mon.below_uv_trip = s.below_uv_trip;
endmodule

/* logic/ovm_limit_monitor.sv */
// Purpose: Output voltage limit registers, flags and undervoltage trip response
// Assumes: Command port is driven by the management bus front end on mclk
// Notes:   Overvoltage trip itself is detected outside; only its flag and hold live here
`timescale 1ns/1ns
module ovm_limit_monitor
    import ovm_pkg::*;
#(
    parameter int MS_CYC = MS_CYCLES
)
(
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_wdata,
    output wire logic        cmd_ack,
    output wire logic        cmd_reject,
    output wire logic [15:0] cmd_rdata,
    input  wire logic [15:0] vout_code,
    input  wire logic        power_good,
    input  wire logic        ramping,
    input  wire logic        operation_on,
    input  wire logic        other_fault_off,
    input  wire logic        ov_trip_active,
    input  wire logic        ov_retry_selected,
    input  wire logic [15:0] turn_on_wait,
    input  wire logic        enable_pin,
    input  wire logic        bias_ok_pin,
    input  wire logic [15:0] setpoint_strap_pin,
    output wire logic        output_enable,
    output wire logic        ov_restart_hold,
    output wire logic        alert_out,
    output wire logic        alert_oe_n
);
    typedef struct packed {
        logic [2:0]    en_sync;
        logic [2:0]    bias_sync;
        logic          en_level;
        logic          bias_level;
        logic [1:0]    boot_cnt;
        logic          boot_done;
        logic [15:0]   ov_warn;
        logic [15:0]   uv_warn;
        logic [15:0]   uv_trip;
        logic [7:0]    action;
        logic [7:0]    flags;
        ovm_state_type fsm;
        logic          retry_elapsed;
        logic          out_en;
        logic          ov_hold;
        logic          ack;
        logic          reject;
        logic [15:0]   rdata;
        logic          tmr_start;
        logic [15:0]   tmr_ms;
        logic          alert;
    } ovm_mon_type;

    ovm_mon_type s;
    ovm_mon_type next_s;
    ovm_mon_if   mon ();

    logic        cmd_off;
    logic        stop_retry;
    logic        uv_mask;
    logic        clear_req;
    logic [7:0]  flag_set;
    logic [15:0] retry_ms;

    ovm_ms_timer #(
        .MS_CYC (MS_CYC)
    ) u_timer (
        .mclk (mclk),
        .nrst (nrst),
        .mon  (mon)
    );

    ovm_compare u_compare (
        .mclk (mclk),
        .nrst (nrst),
        .mon  (mon)
    );

    assign mon.tmr_start = s.tmr_start;
    assign mon.tmr_ms    = s.tmr_ms;
    assign mon.vout      = vout_code;
    assign mon.ov_warn   = s.ov_warn;
    assign mon.uv_warn   = s.uv_warn;
    assign mon.uv_trip   = s.uv_trip;

    always_comb
    begin
        next_s = s;
        next_s.ack = 1'b0;
        next_s.reject = 1'b0;
        next_s.tmr_start = 1'b0;

        // Pin synchronisers, a change counts once stages two and three agree
        next_s.en_sync = {s.en_sync[1:0], enable_pin};
        next_s.bias_sync = {s.bias_sync[1:0], bias_ok_pin};
        if (s.en_sync[1] == s.en_sync[2])
            next_s.en_level = s.en_sync[2];
        if (s.bias_sync[1] == s.bias_sync[2])
            next_s.bias_level = s.bias_sync[2];

        cmd_off = !s.en_level || !operation_on;
        stop_retry = cmd_off || !s.bias_level || other_fault_off;
        clear_req = cmd_valid && cmd_write && (cmd_code == CMD_CLEAR_FAULTS) && s.boot_done;

        // Strap-derived defaults loaded once the strap has settled
        if (!s.boot_done)
        begin
            if (s.boot_cnt == STRAP_SETTLE)
            begin
                next_s.boot_done = 1'b1;
                next_s.ov_warn = ovm_scale(setpoint_strap_pin, OV_WARN_SCALE);
                next_s.uv_warn = ovm_scale(setpoint_strap_pin, UV_WARN_SCALE);
            end
            else
                next_s.boot_cnt = s.boot_cnt + 2'h1;
        end

        // Command port decode
        if (cmd_valid)
        begin
            next_s.ack = s.boot_done;
            next_s.reject = !s.boot_done;
            next_s.rdata = 16'h0000;
            if (s.boot_done)
            begin
                case (cmd_code)
                    CMD_OV_WARN, CMD_UV_WARN, CMD_UV_TRIP:
                    begin
                        if (cmd_write)
                        begin
                            if (!ovm_limit_ok(cmd_wdata))
                            begin
                                next_s.ack = 1'b0;
                                next_s.reject = 1'b1;
                            end
                            else if (cmd_code == CMD_OV_WARN)
                                next_s.ov_warn = cmd_wdata;
                            else if (cmd_code == CMD_UV_WARN)
                                next_s.uv_warn = cmd_wdata;
                            else
                                next_s.uv_trip = cmd_wdata;
                        end
                        else if (cmd_code == CMD_OV_WARN)
                            next_s.rdata = s.ov_warn;
                        else if (cmd_code == CMD_UV_WARN)
                            next_s.rdata = s.uv_warn;
                        else
                            next_s.rdata = s.uv_trip;
                    end
                    CMD_UV_ACTION:
                    begin
                        if (cmd_write)
                            next_s.action = cmd_wdata[7:0];
                        else
                            next_s.rdata = {8'h00, s.action};
                    end
                    CMD_CLEAR_FAULTS:
                    begin
                        if (!cmd_write)
                        begin
                            next_s.ack = 1'b0;
                            next_s.reject = 1'b1;
                        end
                    end
                    CMD_SUMMARY, CMD_VOUT_FLAGS:
                    begin
                        if (cmd_write)
                        begin
                            next_s.ack = 1'b0;
                            next_s.reject = 1'b1;
                        end
                        else if (cmd_code == CMD_VOUT_FLAGS)
                            next_s.rdata = {8'h00, s.flags};
                        else
                            next_s.rdata = {(s.flags != 8'h00), 15'h0000};
                    end
                    default:
                    begin
                        next_s.ack = 1'b0;
                        next_s.reject = 1'b1;
                    end
                endcase
            end
        end

        uv_mask = ramping || !power_good || cmd_off || (s.fsm != ST_RUN);

        flag_set = 8'h00;
        flag_set[FLAG_OV_WARN] = mon.above_ov_warn;
        flag_set[FLAG_OV_TRIP] = ov_trip_active;
        flag_set[FLAG_UV_WARN] = !uv_mask && mon.below_uv_warn;
        flag_set[FLAG_UV_TRIP] = !uv_mask && mon.below_uv_trip;

        // Sticky flags, a new event beats a clear
        next_s.flags = (clear_req ? FLAGS_RESET : s.flags) | flag_set;
        next_s.alert = (next_s.flags != FLAGS_RESET);

        next_s.ov_hold = ov_retry_selected && mon.above_ov_warn;

        // Retry spacing in 35 ms steps
        retry_ms = 16'({13'h0000, s.action[DELAY_MSB:DELAY_LSB]} + 16'h0001) * RETRY_UNIT_MS;

        case (s.fsm)
            ST_RUN:
            begin
                // Disable then retry on action 10
                if (flag_set[FLAG_UV_TRIP] && (s.action[ACT_MSB:ACT_LSB] == ACT_DISABLE_RETRY))
                begin
                    // No retry latches the output off
                    if (s.action[RETRY_MSB:RETRY_LSB] == RETRY_NONE)
                        next_s.fsm = ST_LATCHED;
                    else
                    begin
                        next_s.fsm = ST_RETRY_WAIT;
                        next_s.retry_elapsed = 1'b0;
                        next_s.tmr_start = 1'b1;
                        next_s.tmr_ms = retry_ms;
                    end
                end
            end
            ST_RETRY_WAIT:
            begin
                // Retrying ends on off, bias loss, other fault
                if (stop_retry)
                    next_s.fsm = ST_RUN;
                else
                begin
                    if (mon.tmr_done)
                        next_s.retry_elapsed = 1'b1;
                    if ((s.retry_elapsed || mon.tmr_done) && !s.ov_hold)
                    begin
                        next_s.fsm = ST_TON_WAIT;
                        next_s.tmr_start = 1'b1;
                        next_s.tmr_ms = turn_on_wait;
                    end
                end
            end
            ST_TON_WAIT:
            begin
                if (stop_retry || mon.tmr_done)
                    next_s.fsm = ST_RUN;
            end
            ST_LATCHED:
            begin
                if (clear_req)
                    next_s.fsm = ST_RUN;
            end
            default:
                next_s.fsm = ST_RUN;
        endcase

        next_s.out_en = (next_s.fsm == ST_RUN);
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            s <= '0;
            s.uv_trip <= UV_TRIP_RESET;
            s.ov_warn <= LIMIT_MAX;
            s.uv_warn <= LIMIT_RESET;
            s.action <= UV_ACTION_RESET;
            s.flags <= FLAGS_RESET;
            s.fsm <= ST_RUN;
            s.out_en <= 1'b1;
        end
        else
            s <= next_s;
    end

    assign cmd_ack         = s.ack;
    assign cmd_reject      = s.reject;
    assign cmd_rdata       = s.rdata;
    assign output_enable   = s.out_en;
    assign ov_restart_hold = s.ov_hold;
    assign alert_out       = 1'b0;
    assign alert_oe_n      = !s.alert;
endmodule

/* testbench/ovm_limit_monitor_assertions.sv */
// Purpose: Port-level checks of the output voltage limit monitor
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound into every instance of the monitor
`timescale 1ns/1ns
module ovm_limit_monitor_assertions
    import ovm_pkg::*;
(
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic        cmd_valid,
    input wire logic        cmd_write,
    input wire logic [7:0]  cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic        cmd_ack,
    input wire logic        cmd_reject,
    input wire logic [15:0] cmd_rdata,
    input wire logic        power_good,
    input wire logic        ramping,
    input wire logic        ov_retry_selected,
    input wire logic        output_enable,
    input wire logic        ov_restart_hold,
    input wire logic        alert_out,
    input wire logic        alert_oe_n
);
    logic [2:0] boot_cnt;
    logic       limit_cmd;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    assign limit_cmd = (cmd_code == CMD_OV_WARN) || (cmd_code == CMD_UV_WARN) || (cmd_code == CMD_UV_TRIP);

    // Edges since reset release, saturating
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            boot_cnt <= 3'h0;
        else if (boot_cnt != 3'h7)
            boot_cnt <= boot_cnt + 3'h1;
    end

    answer_once_a:
        assert property (cmd_valid |=> cmd_ack != cmd_reject) else $error("answer count wrong");
    idle_quiet_a:
        assert property (!cmd_valid |=> !cmd_ack && !cmd_reject) else $error("answer without command");
    range_refuse_a:
        assert property (cmd_valid && cmd_write && limit_cmd && cmd_wdata > LIMIT_MAX |=> cmd_reject)
            else $error("out of range limit accepted");
    boot_refuse_a:
        assert property (cmd_valid && boot_cnt < 3'h4 |=> cmd_reject) else $error("command taken during boot");
    reject_zero_a:
        assert property (cmd_reject |-> cmd_rdata == 16'h0000) else $error("refused command returned data");
    alert_low_a:
        assert property (alert_out == 1'b0) else $error("alert line driven high");
    trip_alerts_a:
        assert property ($fell(output_enable) |-> ##[0:1] !alert_oe_n) else $error("shutdown without alert");
    uv_masked_a:
        assert property ((ramping || !power_good) [*2] |=> !$fell(output_enable))
            else $error("shutdown while undervoltage masked");
    alert_release_a:
        assert property ($rose(alert_oe_n) |-> cmd_ack || $past(cmd_ack)) else $error("alert released without clear");
    ov_hold_gate_a:
        assert property (!$past(ov_retry_selected) && !$past(ov_retry_selected, 2) |-> !ov_restart_hold)
            else $error("restart hold without retry");

    cover property ($fell(output_enable));
    cover property ($rose(output_enable));
    cover property (cmd_valid && cmd_write && cmd_code == CMD_CLEAR_FAULTS);
endmodule

bind ovm_limit_monitor ovm_limit_monitor_assertions u_chk (
    .mclk (mclk), .nrst (nrst), .cmd_valid (cmd_valid), .cmd_write (cmd_write),
    .cmd_code (cmd_code), .cmd_wdata (cmd_wdata), .cmd_ack (cmd_ack), .cmd_reject (cmd_reject),
    .cmd_rdata (cmd_rdata), .power_good (power_good), .ramping (ramping),
    .ov_retry_selected (ov_retry_selected), .output_enable (output_enable),
    .ov_restart_hold (ov_restart_hold), .alert_out (alert_out), .alert_oe_n (alert_oe_n)
);

/* testbench/ovm_host_model.sv */
// Purpose: Management bus host issuing commands to the limit monitor
// Assumes: Answer arrives one cycle after the command is taken
// Notes:   Idle fields carry inverted data so stale values never match
`timescale 1ns/1ns
module ovm_host_model
(
    input  wire logic        mclk,
    output logic             cmd_valid,
    output logic             cmd_write,
    output logic [7:0]       cmd_code,
    output logic [15:0]      cmd_wdata,
    input  wire logic        cmd_ack,
    input  wire logic        cmd_reject,
    input  wire logic [15:0] cmd_rdata
);
    initial
    begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 16'h0000;
    end

    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                        output logic ack, output logic rej, output logic [15:0] rdata);
        @(posedge mclk);
        #1;
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_code  = code;
        cmd_wdata = data;
        @(posedge mclk);
        #1;
        cmd_valid = 1'b0;
        cmd_code  = ~code;
        cmd_wdata = ~data;
        ack       = cmd_ack;
        rej       = cmd_reject;
        rdata     = cmd_rdata;
    endtask
endmodule

/* testbench/tb_ovm_limit_monitor.sv */
// Purpose: Self-checking bench for the output voltage limit monitor
// Assumes: One millisecond shortened to ten clocks
// Notes:   Commands come from the host model
`timescale 1ns/1ns
module tb_ovm_limit_monitor
    import ovm_pkg::*;
;
    localparam int MS = 10;

    logic        mclk = 1'b0;
    logic        nrst, cmd_valid, cmd_write, cmd_ack, cmd_reject;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata, cmd_rdata, vout_code, turn_on_wait, setpoint_strap_pin;
    logic        power_good, ramping, operation_on, other_fault_off, ov_trip_active;
    logic        ov_retry_selected, enable_pin, bias_ok_pin;
    logic        output_enable, ov_restart_hold, alert_out, alert_oe_n;
    wire         alert_line = alert_oe_n ? 1'b1 : alert_out;
    int          num_errors = 0;
    int          cmp_count = 0;
    int          low_cyc = 0;
    int          last_low = 0;
    int          exp_low;
    logic [7:0]  flag_only [3] = '{8'h00, 8'h58, 8'hc7};
    logic [7:0]  retry_act [2] = '{8'h89, 8'hbf};

    ovm_limit_monitor #(
        .MS_CYC (MS)
    ) DUT (
        .mclk (mclk), .nrst (nrst), .cmd_valid (cmd_valid), .cmd_write (cmd_write),
        .cmd_code (cmd_code), .cmd_wdata (cmd_wdata), .cmd_ack (cmd_ack), .cmd_reject (cmd_reject),
        .cmd_rdata (cmd_rdata), .vout_code (vout_code), .power_good (power_good), .ramping (ramping),
        .operation_on (operation_on), .other_fault_off (other_fault_off), .ov_trip_active (ov_trip_active),
        .ov_retry_selected (ov_retry_selected), .turn_on_wait (turn_on_wait), .enable_pin (enable_pin),
        .bias_ok_pin (bias_ok_pin), .setpoint_strap_pin (setpoint_strap_pin),
        .output_enable (output_enable), .ov_restart_hold (ov_restart_hold),
        .alert_out (alert_out), .alert_oe_n (alert_oe_n)
    );

    ovm_host_model host (
        .mclk (mclk), .cmd_valid (cmd_valid), .cmd_write (cmd_write), .cmd_code (cmd_code),
        .cmd_wdata (cmd_wdata), .cmd_ack (cmd_ack), .cmd_reject (cmd_reject), .cmd_rdata (cmd_rdata)
    );

    always #5 mclk = ~mclk;

    // Length of the latest low stretch of the output enable
    always @(negedge mclk)
    begin
        if (output_enable === 1'b0)
            low_cyc++;
        else
            low_cyc = 0;
        if (low_cyc != 0)
            last_low = low_cyc;
    end

    task automatic final_report;
        if (num_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wr(input logic [7:0] code, input logic [15:0] data, input logic ok);
        logic        a;
        logic        r;
        logic [15:0] d;
        host.xfer(1'b1, code, data, a, r, d);
        chk1("write ack", ok, a);
        chk1("write reject", !ok, r);
    endtask

    task automatic rd(input logic [7:0] code, input logic [15:0] exp, input logic ok);
        logic        a;
        logic        r;
        logic [15:0] d;
        host.xfer(1'b0, code, 16'h0000, a, r, d);
        chk1("read ack", ok, a);
        chk16("read data", ok ? exp : 16'h0000, d);
    endtask

    task automatic wait_oe(input logic lvl);
        for (int n = 0; n < 4000 && output_enable !== lvl; n++)
            tick(1);
    endtask

    task automatic uv_event(input logic [7:0] code);
        wr(CMD_CLEAR_FAULTS, 16'h0000, 1'b1);
        wr(CMD_UV_ACTION, {8'h00, code}, 1'b1);
        vout_code = 16'h0800;
        tick(8);
        rd(CMD_VOUT_FLAGS, 16'h0030, 1'b1);
        vout_code = 16'h1f00;
    endtask

    initial
    begin
        nrst = 1'b0;
        vout_code = 16'h2000;
        {power_good, ramping, operation_on, other_fault_off} = 4'b1010;
        {ov_trip_active, ov_retry_selected, enable_pin, bias_ok_pin} = 4'b0011;
        turn_on_wait = 16'h0002;
        setpoint_strap_pin = 16'h2000;
        repeat (10) @(posedge mclk);
        #1;
        nrst = 1'b1;
        rd(CMD_OV_WARN, 16'h0000, 1'b0);
        tick(4);
        rd(CMD_OV_WARN, 16'h2290, 1'b1);
        rd(CMD_UV_WARN, 16'h1c28, 1'b1);
        rd(CMD_UV_TRIP, 16'h0ccd, 1'b1);
        rd(CMD_UV_ACTION, 16'h00b8, 1'b1);
        // Limits swing to the range end, so undervoltage stays masked
        power_good = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            wr(CMD_OV_WARN + 8'(i), LIMIT_MAX, 1'b1);
            wr(CMD_OV_WARN + 8'(i), 16'hb001, 1'b0);
            rd(CMD_OV_WARN + 8'(i), LIMIT_MAX, 1'b1);
        end
        wr(CMD_OV_WARN, 16'h2000, 1'b1);
        wr(CMD_UV_WARN, 16'h1800, 1'b1);
        wr(CMD_UV_TRIP, 16'h1000, 1'b1);
        wr(CMD_SUMMARY, 16'h0000, 1'b0);
        wr(CMD_VOUT_FLAGS, 16'h0000, 1'b0);
        rd(CMD_CLEAR_FAULTS, 16'h0000, 1'b0);
        rd(8'h50, 16'h0000, 1'b0);
        wr(CMD_UV_ACTION, 16'hff89, 1'b1);
        rd(CMD_UV_ACTION, 16'h0089, 1'b1);
        rd(CMD_VOUT_FLAGS, 16'h0000, 1'b1);
        power_good = 1'b1;
        {ov_retry_selected, ov_trip_active} = 2'b11;
        vout_code = 16'h2100;
        tick(4);
        ov_trip_active = 1'b0;
        chk1("restart hold", 1'b1, ov_restart_hold);
        chk1("alert line", 1'b0, alert_line);
        rd(CMD_VOUT_FLAGS, 16'h00c0, 1'b1);
        rd(CMD_SUMMARY, 16'h8000, 1'b1);
        vout_code = 16'h1f00;
        tick(4);
        chk1("restart hold", 1'b0, ov_restart_hold);
        rd(CMD_VOUT_FLAGS, 16'h00c0, 1'b1);
        wr(CMD_CLEAR_FAULTS, 16'h0000, 1'b1);
        rd(CMD_VOUT_FLAGS, 16'h0000, 1'b1);
        tick(2);
        chk1("alert line", 1'b1, alert_line);
        ov_retry_selected = 1'b0;
        vout_code = 16'h0800;
        for (int i = 0; i < 2; i++)
        begin
            ramping = 1'(i == 0);
            power_good = 1'(i == 0);
            tick(8);
            chk1("masked enable", 1'b1, output_enable);
            rd(CMD_VOUT_FLAGS, 16'h0000, 1'b1);
        end
        vout_code = 16'h1f00;
        tick(3);
        power_good = 1'b1;
        foreach (flag_only[i])
        begin
            uv_event(flag_only[i]);
            chk1("flag only enable", 1'b1, output_enable);
        end
        foreach (retry_act[i])
        begin
            exp_low = (int'(retry_act[i][2:0]) + 1) * 35 * MS + 2 * MS + 2;
            uv_event(retry_act[i]);
            chk1("trip enable", 1'b0, output_enable);
            chk1("alert line", 1'b0, alert_line);
            wait_oe(1'b1);
            chk1("retry span", 1'b1, last_low >= exp_low && last_low <= exp_low + 3);
        end
        uv_event(8'h80);
        tick(500);
        chk1("latched enable", 1'b0, output_enable);
        wr(CMD_CLEAR_FAULTS, 16'h0000, 1'b1);
        tick(2);
        chk1("cleared enable", 1'b1, output_enable);
        uv_event(8'hb8);
        chk1("retry enable", 1'b0, output_enable);
        other_fault_off = 1'b1;
        tick(3);
        chk1("aborted enable", 1'b1, output_enable);
        other_fault_off = 1'b0;
        final_report;
    end

    initial
    begin
        #400000;
        num_errors++;
        final_report;
    end
endmodule
